// [logic/monitor_output_selector_pkg.sv]
`default_nettype none
package monitor_output_selector_pkg;
	localparam int NUM_OUTPUTS = 11;
	localparam int NUM_INPUTS  = 4;
	localparam int SEL_W       = 5;
	localparam int APB_ADDR_W  = 8;
	localparam int DELAY_W     = 4;

	// register byte offsets; select word for output n at SEL_BASE_OFS + 4*(n-1)
	localparam logic [7:0] SEL_BASE_OFS = 8'h00;
	localparam logic [7:0] LOGIC_OFS    = 8'h2c;
	localparam logic [7:0] DELAY_OFS    = 8'h30;
	localparam logic [7:0] CTRL_OFS     = 8'h34;
	localparam logic [7:0] FLAGS_OFS    = 8'h38;
	localparam logic [7:0] MON_OFS      = 8'h3c;

	// control word fields
	localparam int CTRL_ERR_RESET_BIT = 0;
	localparam int CTRL_VARIANT_LSB   = 1;
	localparam int VAR_SHUT_PRI       = 0;
	localparam int VAR_SHUT_SEC       = 1;
	localparam int VAR_MAIN_VALVE     = 2;
	localparam int VAR_SPARK          = 3;

	// reset values
	localparam logic [SEL_W-1:0]       SEL_RESET_VAL     = 5'h00;
	localparam logic [NUM_OUTPUTS-1:0] LOGIC_RESET_VAL   = 11'h000;
	localparam logic [DELAY_W-1:0]     DELAY_RESET_VAL   = 4'h0;
	localparam logic [DELAY_W-1:0]     DELAY_MAX         = 4'ha;
	localparam logic [3:0]             VARIANT_RESET_VAL = 4'h0;

	// timing: off delay steps in whole seconds
	localparam int CLK_PERIOD_NS  = 50;
	localparam int SECOND_NS      = 1000000000;
	localparam int SEC_CYCLES     = SECOND_NS / CLK_PERIOD_NS;

	// only these outputs (zero based) may carry the drive-request sources
	localparam int DRIVE_FIRST_OUT = 8;

	// source codes
	localparam logic [SEL_W-1:0] SRC_UNUSED      = 5'h00;
	localparam logic [SEL_W-1:0] SRC_PILOT_IGN   = 5'h01;
	localparam logic [SEL_W-1:0] SRC_PILOT_LOSS  = 5'h02;
	localparam logic [SEL_W-1:0] SRC_PILOT_FALSE = 5'h03;
	localparam logic [SEL_W-1:0] SRC_MISC        = 5'h04;
	localparam logic [SEL_W-1:0] SRC_WARNING     = 5'h05;
	localparam logic [SEL_W-1:0] SRC_HI_TEMP     = 5'h06;
	localparam logic [SEL_W-1:0] SRC_SHUT_PRI    = 5'h07;
	localparam logic [SEL_W-1:0] SRC_SHUT_SEC    = 5'h08;
	localparam logic [SEL_W-1:0] SRC_RUN         = 5'h09;
	localparam logic [SEL_W-1:0] SRC_PILOT_DET   = 5'h0a;
	localparam logic [SEL_W-1:0] SRC_MAIN_IGN    = 5'h0b;
	localparam logic [SEL_W-1:0] SRC_MAIN_LOSS   = 5'h0c;
	localparam logic [SEL_W-1:0] SRC_MAIN_FALSE  = 5'h0d;
	localparam logic [SEL_W-1:0] SRC_MAIN_DET    = 5'h0e;
	localparam logic [SEL_W-1:0] SRC_COMB_IGN    = 5'h0f;
	localparam logic [SEL_W-1:0] SRC_COMB_LOSS   = 5'h10;
	localparam logic [SEL_W-1:0] SRC_COMB_FALSE  = 5'h11;
	localparam logic [SEL_W-1:0] SRC_COMB_DET    = 5'h12;
	localparam logic [SEL_W-1:0] SRC_ERR_SEL     = 5'h13;
	localparam logic [SEL_W-1:0] SRC_AIR_VALVE   = 5'h14;
	localparam logic [SEL_W-1:0] SRC_MAIN_VALVE  = 5'h15;
	localparam logic [SEL_W-1:0] SRC_SPARK       = 5'h16;
	localparam logic [SEL_W-1:0] SRC_RAW_IN1     = 5'h17;
	localparam logic [SEL_W-1:0] SRC_DLY_IN1     = 5'h1b;
	localparam logic [SEL_W-1:0] SRC_LAST        = 5'h1e;

	// error flags; the same layout carries one-cycle set events
	typedef struct packed {
		logic pilotIgn;
		logic pilotLoss;
		logic pilotFalse;
		logic misc;
		logic pilotDetect;
		logic mainIgn;
		logic mainLoss;
		logic mainFalse;
		logic mainDetect;
	} err_flags_type;

	// levels from the sequence engine
	typedef struct packed {
		logic warning;
		logic hiTemp;
		logic shutterPri;
		logic shutterSec;
		logic standby;
		logic startup;
		logic airReq;
		logic mainValveReq;
		logic sparkReq;
	} seq_status_type;
endpackage : monitor_output_selector_pkg
`default_nettype wire

// [logic/monitor_output_selector.sv]
// Operation
// - pilot flame loss source on while flag latched, off after error reset
// - pilot false flame source held on until error reset
// - misc source on for other errors only, off after error reset
// - warning source follows warning level, no error reset needed
// - high temperature source on exactly while in high temperature mode
// - shutter sources follow shutter, forced off when variant lacks support
// - run source set by startup once standby has begun
// - pilot detect circuit error source on until error reset
// - main burner error sources each follow their own latched flag
// - combined sources are pilot OR main of the same error
// - error type selector set by any of the four main errors
// - error type selector off when normal or any other error occurs
// - air valve source follows request, only on outputs nine to eleven
// - main valve source follows request, outputs nine to eleven, gated by variant
// - spark source follows request, outputs nine to eleven, gated by variant
// - drive sources not accepted on outputs one to eight
// - raw interlock sources show synchronised input, no off delay
// - delayed interlock sources drop only after configured off delay; here the shared tick can drop them up to a step early
// - unused output is off
// - pilot ignition failure source on until error reset
// - eleven outputs, each with its own source select
// - per-output reverse setting inverts the driven level
// - off delay per input is zero to ten seconds in one second steps
`timescale 1ns/1ps
`default_nettype none
module monitor_output_selector
	import monitor_output_selector_pkg::*;
#(
	parameter int TICK_CYCLES = SEC_CYCLES
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [APB_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire err_flags_type          errEvent,
	input  wire logic                   errResetReq,
	input  wire seq_status_type         seqStatus,
	input  wire logic [NUM_INPUTS-1:0]  interlockInput,
	output logic      [NUM_OUTPUTS-1:0] monOut
);
	localparam int TICK_W = $clog2(TICK_CYCLES);

	logic [SEL_W-1:0]       selReg_r [NUM_OUTPUTS];
	logic [DELAY_W-1:0]     delayReg_r [NUM_INPUTS];
	logic [DELAY_W-1:0]     delayCnt_r [NUM_INPUTS];
	logic [NUM_OUTPUTS-1:0] logicInv_r;
	logic [3:0]             variant_r;
	err_flags_type          errFlags_r;
	logic                   errSel_r;
	logic                   run_r;
	logic [NUM_INPUTS-1:0]  ilkMeta_r;
	logic [NUM_INPUTS-1:0]  ilkSync_r;
	logic [NUM_INPUTS-1:0]  ilkDelayed_r;
	logic [TICK_W-1:0]      tickCnt_r;
	logic                   tick_r;
	logic [NUM_OUTPUTS-1:0] monOut_r;
	logic [NUM_OUTPUTS-1:0] monNxt;
	logic [31:0]            prdata_r;
	logic                   pready_r;
	logic                   pslverr_r;
	logic [31:0]            srcVec;

	// bus decode
	wire                   setupPhase = psel & ~penable;
	wire                   wrAccess   = psel & penable & pwrite & pready_r;
	wire                   wordAlign  = (paddr[1:0] == 2'b00);
	wire [3:0]             selIdx     = paddr[5:2];
	wire                   isSel      = wordAlign & (paddr[7:2] < 6'd11);
	wire                   isLogic    = (paddr == LOGIC_OFS);
	wire                   isDelay    = (paddr == DELAY_OFS);
	wire                   isCtrl     = (paddr == CTRL_OFS);
	wire                   isFlags    = (paddr == FLAGS_OFS);
	wire                   isMon      = (paddr == MON_OFS);
	wire                   mapped     = isSel | isLogic | isDelay | isCtrl | isFlags | isMon;
	wire [SEL_W-1:0]       wrCode     = pwdata[SEL_W-1:0];
	wire                   wrIsDrive  = (wrCode >= SRC_AIR_VALVE) & (wrCode <= SRC_SPARK);
	// drive codes on outputs one to eight and codes past the last are dropped
	wire                   wrCodeOk   = (wrCode <= SRC_LAST)
		& (~wrIsDrive | (selIdx >= 4'(DRIVE_FIRST_OUT)));
	wire                   errClear   = errResetReq
		| (wrAccess & isCtrl & pwdata[CTRL_ERR_RESET_BIT]);

	// read data; sampled in the setup cycle
	wire [31:0] rdSel   = isSel ? {27'h0, selReg_r[selIdx]} : 32'h0;
	wire [31:0] rdDelay = {16'h0, delayReg_r[3], delayReg_r[2], delayReg_r[1], delayReg_r[0]};
	wire [31:0] rdMux   = isSel   ? rdSel
		: isLogic ? {21'h0, logicInv_r}
		: isDelay ? rdDelay
		: isCtrl  ? {27'h0, variant_r, 1'b0}
		: isFlags ? {21'h0, errSel_r, run_r, errFlags_r}
		: isMon   ? {13'h0, ilkDelayed_r, ilkSync_r, monOut_r}
		: 32'h0;

	// no wait state: pready is already high in the first access cycle, never stretched
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= setupPhase;
			pslverr_r <= setupPhase & ~mapped;
			if (setupPhase) begin
				prdata_r <= pwrite ? 32'h0 : rdMux;
			end
		end
	end

	// select registers; a refused code leaves the old choice in place
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_OUTPUTS; i++) begin
				selReg_r[i] <= SEL_RESET_VAL;
			end
		end else if (wrAccess & isSel & wrCodeOk) begin
			selReg_r[selIdx] <= wrCode;
		end
	end

	// logic sense, variant support and off delays
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			logicInv_r <= LOGIC_RESET_VAL;
			variant_r  <= VARIANT_RESET_VAL;
			for (int i = 0; i < NUM_INPUTS; i++) begin
				delayReg_r[i] <= DELAY_RESET_VAL;
			end
		end else if (wrAccess) begin
			if (isLogic) begin
				logicInv_r <= pwdata[NUM_OUTPUTS-1:0];
			end
			if (isCtrl) begin
				variant_r <= pwdata[CTRL_VARIANT_LSB+3:CTRL_VARIANT_LSB];
			end
			if (isDelay) begin
				for (int i = 0; i < NUM_INPUTS; i++) begin
					// values above ten seconds clamp to ten
					delayReg_r[i] <= (pwdata[i*DELAY_W +: DELAY_W] > DELAY_MAX) ? DELAY_MAX
						: pwdata[i*DELAY_W +: DELAY_W];
				end
			end
		end
	end

	// latched errors: a set in the clearing cycle wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			errFlags_r <= '0;
		end else begin
			errFlags_r <= (errClear ? err_flags_type'('0) : errFlags_r) | errEvent;
		end
	end

	// error type selector: main errors set it, any other error drops it
	wire mainEvent  = errEvent.mainIgn | errEvent.mainLoss | errEvent.mainFalse
		| errEvent.mainDetect;
	wire otherEvent = errEvent.pilotIgn | errEvent.pilotLoss | errEvent.pilotFalse
		| errEvent.misc | errEvent.pilotDetect;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			errSel_r <= 1'b0;
		end else if (mainEvent) begin
			errSel_r <= 1'b1;
		end else if (otherEvent | errClear) begin
			errSel_r <= 1'b0;
		end
	end

	// run state: startup only counts once standby is under way
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
		end else if (!seqStatus.standby) begin
			run_r <= 1'b0;
		end else if (seqStatus.startup) begin
			run_r <= 1'b1;
		end
	end

	// one second enable; a shared divider, so a delay may end up to a step early
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickCnt_r <= '0;
			tick_r    <= 1'b0;
		end else begin
			tick_r    <= (tickCnt_r == TICK_W'(TICK_CYCLES - 1));
			tickCnt_r <= (tickCnt_r == TICK_W'(TICK_CYCLES - 1)) ? '0 : tickCnt_r + 1'b1;
		end
	end

	// interlock pins cross in through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ilkMeta_r <= '0;
			ilkSync_r <= '0;
		end else begin
			ilkMeta_r <= interlockInput;
			ilkSync_r <= ilkMeta_r;
		end
	end

	// off delay per input: reload while closed, count seconds once open
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ilkDelayed_r <= '0;
			for (int i = 0; i < NUM_INPUTS; i++) begin
				delayCnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_INPUTS; i++) begin
				if (ilkSync_r[i]) begin
					ilkDelayed_r[i] <= 1'b1;
					delayCnt_r[i]   <= delayReg_r[i];
				end else if (delayCnt_r[i] == '0) begin
					ilkDelayed_r[i] <= 1'b0;
				end else if (tick_r) begin
					delayCnt_r[i] <= delayCnt_r[i] - 1'b1;
				end
			end
		end
	end

	// source vector, indexed by source code
	assign srcVec[SRC_UNUSED]      = 1'b0;
	assign srcVec[SRC_PILOT_IGN]   = errFlags_r.pilotIgn;
	assign srcVec[SRC_PILOT_LOSS]  = errFlags_r.pilotLoss;
	assign srcVec[SRC_PILOT_FALSE] = errFlags_r.pilotFalse;
	assign srcVec[SRC_MISC]        = errFlags_r.misc;
	assign srcVec[SRC_WARNING]     = seqStatus.warning;
	assign srcVec[SRC_HI_TEMP]     = seqStatus.hiTemp;
	assign srcVec[SRC_SHUT_PRI]    = seqStatus.shutterPri & variant_r[VAR_SHUT_PRI];
	assign srcVec[SRC_SHUT_SEC]    = seqStatus.shutterSec & variant_r[VAR_SHUT_SEC];
	assign srcVec[SRC_RUN]         = run_r;
	assign srcVec[SRC_PILOT_DET]   = errFlags_r.pilotDetect;
	assign srcVec[SRC_MAIN_IGN]    = errFlags_r.mainIgn;
	assign srcVec[SRC_MAIN_LOSS]   = errFlags_r.mainLoss;
	assign srcVec[SRC_MAIN_FALSE]  = errFlags_r.mainFalse;
	assign srcVec[SRC_MAIN_DET]    = errFlags_r.mainDetect;
	assign srcVec[SRC_COMB_IGN]    = errFlags_r.pilotIgn | errFlags_r.mainIgn;
	assign srcVec[SRC_COMB_LOSS]   = errFlags_r.pilotLoss | errFlags_r.mainLoss;
	assign srcVec[SRC_COMB_FALSE]  = errFlags_r.pilotFalse | errFlags_r.mainFalse;
	assign srcVec[SRC_COMB_DET]    = errFlags_r.pilotDetect | errFlags_r.mainDetect;
	assign srcVec[SRC_ERR_SEL]     = errSel_r;
	assign srcVec[SRC_AIR_VALVE]   = seqStatus.airReq;
	assign srcVec[SRC_MAIN_VALVE]  = seqStatus.mainValveReq & variant_r[VAR_MAIN_VALVE];
	assign srcVec[SRC_SPARK]       = seqStatus.sparkReq & variant_r[VAR_SPARK];
	assign srcVec[31]              = 1'b0;

	// interlock sources, raw and delayed
	for (genvar k = 0; k < NUM_INPUTS; k++) begin : g_ilk
		assign srcVec[SRC_RAW_IN1 + k] = ilkSync_r[k];
		assign srcVec[SRC_DLY_IN1 + k] = ilkDelayed_r[k];
	end

	// per-output mux; drive codes are also masked on low outputs as a backstop
	for (genvar n = 0; n < NUM_OUTPUTS; n++) begin : g_out
		wire isDrive = (selReg_r[n] >= SRC_AIR_VALVE) & (selReg_r[n] <= SRC_SPARK);
		wire srcOn   = (isDrive & (n < DRIVE_FIRST_OUT)) ? 1'b0 : srcVec[selReg_r[n]];
		assign monNxt[n] = srcOn ^ logicInv_r[n];
	end

	// registered outputs keep the transistors glitch free
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			monOut_r <= '0;
		end else begin
			monOut_r <= monNxt;
		end
	end

	assign monOut  = monOut_r;
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_lossSet;
		errEvent.pilotLoss |=> errFlags_r.pilotLoss ##1 (errFlags_r.pilotLoss || $past(errClear));
	endproperty
	a_lossSet: assert property (p_lossSet) else $error("loss flag not latched");

	property p_falseHold;
		errFlags_r.pilotFalse && !errClear |=> errFlags_r.pilotFalse;
	endproperty
	a_falseHold: assert property (p_falseHold) else $error("false flame flag dropped");

	property p_clearAll;
		errClear && (errEvent == '0) |=> (errFlags_r == '0) && !errSel_r;
	endproperty
	a_clearAll: assert property (p_clearAll) else $error("error reset failed");

	property p_warnOut;
		selReg_r[0] == SRC_WARNING && !logicInv_r[0] && seqStatus.warning
			|=> monOut_r[0];
	endproperty
	a_warnOut: assert property (p_warnOut) else $error("warning not on output");

	property p_unusedOff;
		(selReg_r[1] == SRC_UNUSED) && !logicInv_r[1] [*2] |-> !monOut_r[1];
	endproperty
	a_unusedOff: assert property (p_unusedOff) else $error("unused output on");

	property p_reverse;
		(selReg_r[2] == SRC_UNUSED) && logicInv_r[2] [*2] |-> monOut_r[2];
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse logic wrong");

	property p_noDriveLow;
		!((selReg_r[0] >= SRC_AIR_VALVE) && (selReg_r[0] <= SRC_SPARK));
	endproperty
	a_noDriveLow: assert property (p_noDriveLow) else $error("drive code on output one");

	property p_shutterGate;
		!variant_r[VAR_SHUT_SEC] |-> !srcVec[SRC_SHUT_SEC];
	endproperty
	a_shutterGate: assert property (p_shutterGate) else $error("shutter without support");

	property p_runSet;
		seqStatus.standby && seqStatus.startup |=> run_r;
	endproperty
	a_runSet: assert property (p_runSet) else $error("run not entered");

	property p_errSelMain;
		mainEvent |=> errSel_r;
	endproperty
	a_errSelMain: assert property (p_errSelMain) else $error("selector not set");

	property p_errSelOther;
		otherEvent && !mainEvent |=> !errSel_r;
	endproperty
	a_errSelOther: assert property (p_errSelOther) else $error("selector not cleared");

	property p_combined;
		errFlags_r.mainDetect |-> srcVec[SRC_COMB_DET]
			&& (!srcVec[SRC_PILOT_DET] == !errFlags_r.pilotDetect);
	endproperty
	a_combined: assert property (p_combined) else $error("combined source wrong");

	property p_delayHold;
		// a one second delay may end right after the open edge on a shared tick
		$fell(ilkSync_r[0]) && (delayReg_r[0] > 4'h1) |=> ilkDelayed_r[0] [*2];
	endproperty
	a_delayHold: assert property (p_delayHold) else $error("off delay skipped");

	property p_delayZero;
		$fell(ilkSync_r[1]) && (delayReg_r[1] == '0) |=> !ilkDelayed_r[1];
	endproperty
	a_delayZero: assert property (p_delayZero) else $error("zero delay not immediate");

	property p_ignLatch;
		errEvent.pilotIgn |=> errFlags_r.pilotIgn;
	endproperty
	a_ignLatch: assert property (p_ignLatch) else $error("ignition flag not latched");

	property p_miscSel;
		errEvent.misc && !mainEvent |=> errFlags_r.misc && !errSel_r;
	endproperty
	a_miscSel: assert property (p_miscSel) else $error("misc error not shown alone");

	property p_delayRange;
		delayReg_r[3] <= DELAY_MAX;
	endproperty
	a_delayRange: assert property (p_delayRange) else $error("delay above ten");
endmodule : monitor_output_selector
`default_nettype wire

// [verification/indicator_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// lamps wired to the monitor transistors, seen one clock behind the pins
module indicator_bank
	import monitor_output_selector_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic [NUM_OUTPUTS-1:0] monOut,
	output logic      [NUM_OUTPUTS-1:0] lampOn
);
	// a lamp only shows settled levels, so one register stands in for it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) lampOn <= '0;
		else lampOn <= monOut;
	end
endmodule : indicator_bank
`default_nettype wire

// [verification/test_monitor_output_selector.sv]
`timescale 1ns/1ps
`default_nettype none
module test_monitor_output_selector;
	import monitor_output_selector_pkg::*;
	// short second tick keeps the off delay test to a few dozen cycles
	localparam int TICK = 8;
	logic                   core_clk       = 1'b0;
	logic                   rst_n          = 1'b0;
	logic                   psel           = 1'b0;
	logic                   penable        = 1'b0;
	logic                   pwrite         = 1'b0;
	logic                   errResetReq    = 1'b0;
	logic                   sampleReq      = 1'b0;
	logic [APB_ADDR_W-1:0]  paddr          = '0;
	logic [31:0]            pwdata         = '0;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	err_flags_type          errEvent       = '0;
	seq_status_type         seqStatus      = '0;
	logic [NUM_INPUTS-1:0]  interlockInput = '0;
	logic [NUM_OUTPUTS-1:0] monOut;
	logic [NUM_OUTPUTS-1:0] lampOn;
	int                     n_errors       = 0;
	int                     check_count    = 0;
	int                     cycles         = 0;
	integer                 seed           = 32'he9b8;
	logic [32:0]            rdQ[$];
	logic [NUM_OUTPUTS-1:0] monQ[$];
	// reference state worked out from the stimulus
	logic [SEL_W-1:0]       selM[NUM_OUTPUTS];
	logic [NUM_OUTPUTS-1:0] logicM         = '0;
	logic [3:0]             varM           = '0;
	err_flags_type          flM            = '0;
	err_flags_type          ev;
	seq_status_type         st;
	logic                   errSelM        = 1'b0;
	logic                   runM           = 1'b0;
	logic [3:0]             r;

	monitor_output_selector #(.TICK_CYCLES(TICK)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .errEvent(errEvent),
		.errResetReq(errResetReq), .seqStatus(seqStatus),
		.interlockInput(interlockInput), .monOut(monOut)
	);
	indicator_bank lamps (.core_clk(core_clk), .rst_n(rst_n), .monOut(monOut), .lampOn(lampOn));

	always #25 core_clk = ~core_clk;

	// hang guard; a stuck pready would otherwise spin forever
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 10000) begin
			n_errors++;
			$display("Error %0t: timeout", $time);
			end_of_test();
		end
	end

	task cmp_read(input logic [32:0] exp, input logic [32:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: read %h expected %h", $time, got, exp);
		end
	endtask : cmp_read

	task cmp_mon(input logic [NUM_OUTPUTS-1:0] exp, input logic [NUM_OUTPUTS-1:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: lamps %h expected %h", $time, got, exp);
		end
	endtask : cmp_mon

	// watcher: oldest note against each read answer and each lamp sample
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) cmp_read(rdQ.pop_front(), {pslverr, prdata});
		if (sampleReq) cmp_mon(monQ.pop_front(), lampOn);
	end

	// leading edge wait keeps psel from being assigned twice in one step
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [7:0] a, input logic [32:0] exp);
		rdQ.push_back(exp);
		apb(a, 1'b0, 32'h0);
	endtask : rd

	task mon_check(input logic [NUM_OUTPUTS-1:0] exp);
		@(posedge core_clk);
		monQ.push_back(exp);
		sampleReq <= 1'b1;
		@(posedge core_clk);
		sampleReq <= 1'b0;
	endtask : mon_check

	// refused codes leave the old select in place
	task set_sel(input int i, input logic [SEL_W-1:0] c);
		apb(SEL_BASE_OFS + 8'(4 * i), 1'b1, {27'h0, c});
		if (c <= SRC_LAST && !(i < DRIVE_FIRST_OUT && c >= SRC_AIR_VALVE && c <= SRC_SPARK))
			selM[i] = c;
	endtask : set_sel

	function automatic logic src_val(input logic [SEL_W-1:0] c);
		case (c)
			SRC_PILOT_IGN:   return flM.pilotIgn;
			SRC_PILOT_LOSS:  return flM.pilotLoss;
			SRC_PILOT_FALSE: return flM.pilotFalse;
			SRC_MISC:        return flM.misc;
			SRC_WARNING:     return seqStatus.warning;
			SRC_HI_TEMP:     return seqStatus.hiTemp;
			SRC_SHUT_PRI:    return seqStatus.shutterPri & varM[VAR_SHUT_PRI];
			SRC_SHUT_SEC:    return seqStatus.shutterSec & varM[VAR_SHUT_SEC];
			SRC_RUN:         return runM;
			SRC_PILOT_DET:   return flM.pilotDetect;
			SRC_MAIN_IGN:    return flM.mainIgn;
			SRC_MAIN_LOSS:   return flM.mainLoss;
			SRC_MAIN_FALSE:  return flM.mainFalse;
			SRC_MAIN_DET:    return flM.mainDetect;
			SRC_COMB_IGN:    return flM.pilotIgn | flM.mainIgn;
			SRC_COMB_LOSS:   return flM.pilotLoss | flM.mainLoss;
			SRC_COMB_FALSE:  return flM.pilotFalse | flM.mainFalse;
			SRC_COMB_DET:    return flM.pilotDetect | flM.mainDetect;
			SRC_ERR_SEL:     return errSelM;
			SRC_AIR_VALVE:   return seqStatus.airReq;
			SRC_MAIN_VALVE:  return seqStatus.mainValveReq & varM[VAR_MAIN_VALVE];
			SRC_SPARK:       return seqStatus.sparkReq & varM[VAR_SPARK];
			default: begin
				if (c >= SRC_DLY_IN1) return interlockInput[2'(c - SRC_DLY_IN1)];
				if (c >= SRC_RAW_IN1) return interlockInput[2'(c - SRC_RAW_IN1)];
				return 1'b0;
			end
		endcase
	endfunction : src_val

	function automatic logic [NUM_OUTPUTS-1:0] exp_mon();
		for (int i = 0; i < NUM_OUTPUTS; i++) exp_mon[i] = src_val(selM[i]) ^ logicM[i];
	endfunction : exp_mon

	task end_of_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test

	// main sequence: reset values, off delay, then randomised traffic
	initial begin
		for (int i = 0; i < NUM_OUTPUTS; i++) selM[i] = SRC_UNUSED;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < NUM_OUTPUTS; i++) rd(SEL_BASE_OFS + 8'(4 * i), 33'h0);
		for (int a = LOGIC_OFS; a <= MON_OFS + 4; a += 4) rd(8'(a), {a > MON_OFS, 32'h0});
		apb(DELAY_OFS, 1'b1, 32'h0000_f0c5);
		rd(DELAY_OFS, {1'b0, 32'h0000_a0a5});
		set_sel(0, SRC_DLY_IN1);
		set_sel(1, SRC_RAW_IN1);
		interlockInput <= 4'h1;
		repeat (6) @(posedge core_clk);
		mon_check(11'h003);
		interlockInput <= 4'h0;
		repeat (6) @(posedge core_clk);
		mon_check(11'h001);
		repeat (19) @(posedge core_clk);
		mon_check(11'h001);
		repeat (24) @(posedge core_clk);
		mon_check(11'h000);
		apb(DELAY_OFS, 1'b1, 32'h0);
		// warning on output one, reverse logic on unused output three
		logicM = 11'h004;
		apb(LOGIC_OFS, 1'b1, {21'h0, logicM});
		set_sel(0, SRC_WARNING);
		st = '0;
		st.warning = 1'b1;
		seqStatus <= st;
		repeat (3) @(posedge core_clk);
		mon_check(11'h005);
		for (int k = 0; k < 120; k++) begin
			if (k % 20 == 0) begin
				for (int i = 0; i < NUM_OUTPUTS; i++) begin
					set_sel(i, SEL_W'($random(seed)));
					rd(SEL_BASE_OFS + 8'(4 * i), {28'h0, selM[i]});
				end
				logicM = NUM_OUTPUTS'($random(seed));
				apb(LOGIC_OFS, 1'b1, {21'h0, logicM});
				varM = 4'($random(seed));
				apb(CTRL_OFS, 1'b1, {27'h0, varM, 1'b0});
				rd(CTRL_OFS, {28'h0, varM, 1'b0});
			end
			// run needs standby up; startup alone must not set it
			st = seq_status_type'(9'($random(seed)));
			if (!st.standby) runM = 1'b0;
			else if (st.startup) runM = 1'b1;
			seqStatus <= st;
			interlockInput <= 4'($random(seed));
			r = 4'($random(seed));
			if (r < 4'd9) begin
				ev = err_flags_type'(9'h1 << r);
				errEvent <= ev;
				@(posedge core_clk);
				errEvent <= '0;
				flM = flM | ev;
				errSelM = ev.mainIgn | ev.mainLoss | ev.mainFalse | ev.mainDetect;
			end else if (r == 4'd9) begin
				errResetReq <= 1'b1;
				@(posedge core_clk);
				errResetReq <= 1'b0;
				flM = '0;
				errSelM = 1'b0;
			end else if (r == 4'd10) begin
				apb(CTRL_OFS, 1'b1, {27'h0, varM, 1'b1});
				flM = '0;
				errSelM = 1'b0;
			end
			repeat (5) @(posedge core_clk);
			mon_check(exp_mon());
			rd(MON_OFS, {14'h0, interlockInput, interlockInput, exp_mon()});
			rd(FLAGS_OFS, {22'h0, errSelM, runM, flM});
		end
		end_of_test();
	end
endmodule : test_monitor_output_selector
`default_nettype wire
